/* rtl/idehp_drive.sv */
// Drive end of the host port: task file, cache, interrupt and wait states
// What this block does
// [R1] Task file sits at I/O 01F0h to 01F9h
// [R2] Low host reset returns logic to start
// [R3] Sixteen-bit shared bus, driven only on reads
// [R4] Ready held low to stretch cycles
// [R5] Write strobe captures bus into register
// [R6] Read strobe puts register onto bus
// [R7] Address latch enable is ignored
// [R8] Interrupt only when selected and enabled
// [R9] Interrupt cleared by command, status read, reset
// [R10] Word indicator low when data register addressed during a transfer
// [R11] Three address lines select the register
// [R12] Read-ahead fills cache, later reads hit it
// [R13] Media errors recovered without host action
// [R14] Any fitting geometry accepted and translated
// [R15] Format request completes fast, media untouched
// [R16] Interrupt on completion or block ready
`timescale 1ns/100ps
`include "idehp_cfg.svh"
module idehp_drive
    import idehp_pkg::*;
#(
    parameter int CACHE_AW = 6,
    parameter int CAP_LBA  = 32'h0007_FFFF
)
(
    input  wire logic  clk,                     // System clock
    input  wire logic  rst,                     // Synchronous reset
    input  wire logic  master_select_strap,     // Drive answers as drive 0
    idehp_if.drive     bus,                     // Cable side
    output logic [31:0] media_lba,              // Translated block address
    output logic       media_fetch,             // Media fetch request
    input  wire logic  media_ack,               // Media word delivered
    input  wire logic [15:0] media_word         // Media word, already corrected
);
    localparam int CD = 1 << CACHE_AW;
    typedef struct packed
    {
        idehp_dstate_t     st;
        logic [7:0]        err;
        logic [7:0]        cnt;
        logic [7:0]        sec;
        logic [15:0]       cyl;
        logic [7:0]        head;
        logic [7:0]        stat;
        logic [7:0]        heads_cfg;
        logic [7:0]        spt_cfg;
        logic              drive_interrupt_enable_bit;
        logic              irq_pend;
        logic [CD*16-1:0]  cache;
        logic [CACHE_AW:0] fill;
        logic [CACHE_AW:0] rd;
        logic [31:0]       cache_lba;
        logic              cache_ok;
        logic [31:0]       lba;
        logic              fetch;
        logic [15:0]       dout;
        logic              doe;
        logic              rdy_n;
        logic              irq;
        logic              w16_n;
        logic [3:0]        wcnt;
        logic              ior_q;
        logic              iow_q;
    } idehp_drv_t;
    idehp_drv_t cur_ff;
    idehp_drv_t nxt_ff;
    logic       sel;
    logic       rd_edge;
    logic       wr_edge;
    logic       rd_end;
    logic [31:0] chs_lba;
    logic [3:0] ofs;
    // [R11] Address decode
    assign ofs     = bus.cs_ctl ? (`IDEHP_CTL_OFS + {1'b0, bus.addr}) : {1'b0, bus.addr};
    assign sel     = (cur_ff.head[`IDEHP_BIT_DRV] == ~master_select_strap);
    assign rd_edge = !bus.ior_n && cur_ff.ior_q;
    assign wr_edge = bus.iow_n && !cur_ff.iow_q;
    // Read strobe end, word pointer moves only after the host has it
    assign rd_end  = bus.ior_n && !cur_ff.ior_q;
    // [R14] Geometry translation
    assign chs_lba = (32'(cur_ff.cyl) * 32'(cur_ff.heads_cfg) + 32'(cur_ff.head[3:0])) * 32'(cur_ff.spt_cfg)
                   + 32'(cur_ff.sec) - 32'h0000_0001;
    // Next state
    always_comb
    begin
        nxt_ff = cur_ff;
        nxt_ff.ior_q = bus.ior_n;
        nxt_ff.iow_q = bus.iow_n;
        nxt_ff.fetch = 1'b0;
        // [R7] Latch enable unused
        // [R6] Read data driven
        if (!bus.ior_n && sel)
        begin
            nxt_ff.doe = 1'b1;
            case (ofs)
                4'h0: nxt_ff.dout = cur_ff.cache[16*cur_ff.rd[CACHE_AW-1:0] +: 16];
                4'h1: nxt_ff.dout = {8'h00, cur_ff.err};
                4'h2: nxt_ff.dout = {8'h00, cur_ff.cnt};
                4'h3: nxt_ff.dout = {8'h00, cur_ff.sec};
                4'h4: nxt_ff.dout = {8'h00, cur_ff.cyl[7:0]};
                4'h5: nxt_ff.dout = {8'h00, cur_ff.cyl[15:8]};
                4'h6: nxt_ff.dout = {8'h00, cur_ff.head};
                4'h7: nxt_ff.dout = {8'h00, cur_ff.stat};
                4'h8: nxt_ff.dout = {8'h00, cur_ff.stat};
                default: nxt_ff.dout = 16'h0000;
            endcase
        end
        else
        begin
            // [R3] Bus released off reads
            nxt_ff.doe  = 1'b0;
            nxt_ff.dout = 16'h0000;
        end
        // [R4] Stretch first cycles
        if ((!bus.ior_n || !bus.iow_n) && sel && cur_ff.wcnt != `IDEHP_WAIT_CYC)
        begin
            nxt_ff.rdy_n = 1'b1 ^ (cur_ff.wcnt < `IDEHP_WAIT_CYC);
            nxt_ff.wcnt  = cur_ff.wcnt + 4'h1;
        end
        else
            nxt_ff.rdy_n = 1'b1;
        if (bus.ior_n && bus.iow_n)
            nxt_ff.wcnt = 4'h0;
        // [R9] Status read clears pending
        if (rd_edge && sel && ofs == {1'b0, `IDEHP_REG_CMD})
            nxt_ff.irq_pend = 1'b0;
        if (rd_end && sel && ofs == 4'h0 && cur_ff.st == IDEHP_XFER)
        begin
            // [R12] Served from cache
            nxt_ff.rd = cur_ff.rd + 1'b1;
            if (cur_ff.rd[CACHE_AW-1:0] == CACHE_AW'(CD - 1))
            begin
                nxt_ff.stat[`IDEHP_ST_DRQ] = 1'b0;
                nxt_ff.stat[`IDEHP_ST_BSY] = 1'b1;
                nxt_ff.cache_lba = cur_ff.cache_lba + 32'h0000_0001;
                nxt_ff.lba       = cur_ff.cache_lba + 32'h0000_0001;
                nxt_ff.fill      = '0;
                nxt_ff.rd        = '0;
                nxt_ff.st        = IDEHP_FETCH;
            end
        end
        // [R5] Write captured on strobe end
        if (wr_edge)
        begin
            case (ofs)
                4'h1: nxt_ff.heads_cfg = bus.data_h[7:0];
                4'h2: nxt_ff.cnt       = bus.data_h[7:0];
                4'h3: nxt_ff.sec       = bus.data_h[7:0];
                4'h4: nxt_ff.cyl[7:0]  = bus.data_h[7:0];
                4'h5: nxt_ff.cyl[15:8] = bus.data_h[7:0];
                4'h6: nxt_ff.head      = bus.data_h[7:0];
                4'h8: nxt_ff.drive_interrupt_enable_bit       = bus.data_h[`IDEHP_BIT_IEN];
                4'h9: nxt_ff.spt_cfg   = bus.data_h[7:0];
                default: ;
            endcase
            if (ofs == {1'b0, `IDEHP_REG_CMD} && sel)
            begin
                // [R9] New command clears pending
                nxt_ff.irq_pend = 1'b0;
                nxt_ff.err      = 8'h00;
                case (bus.data_h[7:0])
                    `IDEHP_CMD_READ:
                    begin
                        nxt_ff.lba = chs_lba;
                        nxt_ff.stat[`IDEHP_ST_BSY] = 1'b1;
                        // [R12] Hit skips the media
                        if (cur_ff.cache_ok && cur_ff.cache_lba == chs_lba)
                            nxt_ff.st = IDEHP_DONE;
                        else if (chs_lba > CAP_LBA)
                        begin
                            nxt_ff.err = 8'h10;
                            nxt_ff.st  = IDEHP_DONE;
                        end
                        else
                        begin
                            nxt_ff.cache_lba = chs_lba;
                            nxt_ff.cache_ok  = 1'b0;
                            nxt_ff.fill      = '0;
                            nxt_ff.st        = IDEHP_FETCH;
                        end
                        nxt_ff.rd = '0;
                    end
                    // [R15] Format reports done at once
                    `IDEHP_CMD_FORMAT: nxt_ff.st = IDEHP_DONE;
                    default:           nxt_ff.st = IDEHP_DONE;
                endcase
            end
        end
        case (cur_ff.st)
            IDEHP_IDLE: ;
            IDEHP_FETCH:
            begin
                // [R13] Media words arrive corrected
                nxt_ff.fetch = !media_ack;
                if (media_ack)
                begin
                    nxt_ff.cache[16*cur_ff.fill[CACHE_AW-1:0] +: 16] = media_word;
                    nxt_ff.fill = cur_ff.fill + 1'b1;
                    if (cur_ff.fill[CACHE_AW-1:0] == CACHE_AW'(CD - 1))
                    begin
                        nxt_ff.cache_ok = 1'b1;
                        nxt_ff.st       = IDEHP_DONE;
                    end
                end
            end
            IDEHP_DONE:
            begin
                // [R16] Block ready raises interrupt
                nxt_ff.stat[`IDEHP_ST_BSY] = 1'b0;
                nxt_ff.stat[`IDEHP_ST_DRQ] = (cur_ff.err == 8'h00) && cur_ff.cache_ok
                                             && cur_ff.lba == cur_ff.cache_lba;
                nxt_ff.irq_pend = 1'b1;
                nxt_ff.st = nxt_ff.stat[`IDEHP_ST_DRQ] ? IDEHP_XFER : IDEHP_IDLE;
            end
            IDEHP_XFER: ;
            default: nxt_ff.st = IDEHP_IDLE;
        endcase
        // [R8] Gate by select and enable
        nxt_ff.irq = nxt_ff.irq_pend && nxt_ff.drive_interrupt_enable_bit && sel;
        // [R10] Word indicator on data register
        nxt_ff.w16_n = !(sel && !bus.cs_ctl && bus.addr == `IDEHP_REG_DATA && cur_ff.st == IDEHP_XFER);
    end
    // State register
    always_ff @(posedge clk)
    begin
        // [R2] Either reset restarts
        if (rst || !bus.reset_n)
        begin
            cur_ff       <= '0;
            cur_ff.st    <= IDEHP_IDLE;
            cur_ff.stat  <= 8'h50;
            cur_ff.rdy_n <= 1'b1;
            cur_ff.irq   <= 1'b0;
            cur_ff.w16_n <= 1'b1;
            cur_ff.ior_q <= 1'b1;
            cur_ff.iow_q <= 1'b1;
            cur_ff.heads_cfg <= 8'h10;
            cur_ff.spt_cfg   <= 8'h3F;
        end
        else
            cur_ff <= nxt_ff;
    end
    assign bus.data_d                    = cur_ff.dout;
    assign bus.data_d_oe                 = cur_ff.doe;
    assign bus.ready_n                   = cur_ff.rdy_n;
    assign bus.drive_interrupt_line      = cur_ff.irq;
    assign bus.word_transfer_indicator_n = cur_ff.w16_n;
    assign media_lba                     = cur_ff.lba;
    assign media_fetch                   = cur_ff.fetch;
endmodule

/* rtl/idehp_cfg.svh */
// Constants for the drive-side host port and its host adapter end
`ifndef IDEHP_CFG_SVH
`define IDEHP_CFG_SVH
`define IDEHP_IO_BASE      16'h01F0
`define IDEHP_IO_LAST      16'h01F9
`define IDEHP_REG_DATA     3'h0
`define IDEHP_REG_ERROR    3'h1
`define IDEHP_REG_COUNT    3'h2
`define IDEHP_REG_SECTOR   3'h3
`define IDEHP_REG_CYL_LO   3'h4
`define IDEHP_REG_CYL_HI   3'h5
`define IDEHP_REG_HEAD     3'h6
`define IDEHP_REG_CMD      3'h7
`define IDEHP_CTL_OFS      4'h8
`define IDEHP_BIT_IEN      1
`define IDEHP_BIT_DRV      4
`define IDEHP_ST_BSY       7
`define IDEHP_ST_RDY       6
`define IDEHP_ST_DSC       4
`define IDEHP_ST_DRQ       3
`define IDEHP_CMD_READ     8'h20
`define IDEHP_CMD_WRITE    8'h30
`define IDEHP_CMD_FORMAT   8'h50
`define IDEHP_BLOCK_WORDS  9'h100
`define IDEHP_WAIT_CYC     4'h2
`define IDEHP_HOST_HOLD    4'h3
`endif

/* rtl/idehp_pkg.sv */
// Types for both ends of the drive host port, one state type for each end
package idehp_pkg;
    typedef enum logic [3:0]
    {
        IDEHP_IDLE  = 4'b0001,
        IDEHP_XFER  = 4'b0010,
        IDEHP_FETCH = 4'b0100,
        IDEHP_DONE  = 4'b1000
    } idehp_dstate_t;
    typedef enum logic [2:0]
    {
        IDEHP_H_IDLE = 3'b001,
        IDEHP_H_STRB = 3'b010,
        IDEHP_H_END  = 3'b100
    } idehp_hstate_t;
endpackage

/* rtl/idehp_if.sv */
// Cable signals between the host adapter and the drive
`timescale 1ns/100ps
interface idehp_if;
    logic        reset_n;
    logic [15:0] data_h;
    logic        data_h_oe;
    logic [15:0] data_d;
    logic        data_d_oe;
    logic        ready_n;
    logic        iow_n;
    logic        ior_n;
    logic        ale;
    logic [2:0]  addr;
    logic        cs_ctl;
    logic        drive_interrupt_line;
    logic        word_transfer_indicator_n;
    modport drive
    (
        input  reset_n, data_h, data_h_oe, iow_n, ior_n, ale, addr, cs_ctl,
        output data_d, data_d_oe, ready_n, drive_interrupt_line, word_transfer_indicator_n
    );
    modport host
    (
        input  data_d, data_d_oe, ready_n, drive_interrupt_line, word_transfer_indicator_n,
        output reset_n, data_h, data_h_oe, iow_n, ior_n, ale, addr, cs_ctl
    );
endinterface

/* rtl/idehp_host.sv */
// Host adapter end: turns I/O requests into strobed cable cycles
`timescale 1ns/100ps
`include "idehp_cfg.svh"
module idehp_host
    import idehp_pkg::*;
(
    input  wire logic        clk,          // System clock
    input  wire logic        rst,          // Synchronous reset
    input  wire logic        req,          // I/O request pulse
    input  wire logic        req_wr,       // High for write
    input  wire logic [15:0] req_addr,     // I/O address
    input  wire logic [15:0] req_wdata,    // Write data
    output logic             busy,         // Cycle in progress
    output logic             done,         // Cycle finished pulse
    output logic [15:0]      rdata,        // Read data
    output logic             irq,          // Drive interrupt seen
    idehp_if.host            bus           // Cable side
);
    typedef struct packed
    {
        idehp_hstate_t st;
        logic [3:0]    hold;
        logic          wr;
        logic [2:0]    addr;
        logic          ctl;
        logic [15:0]   wd;
        logic [15:0]   rd;
        logic          done;
        logic          rstn;
        logic          irq;
    } idehp_host_t;
    idehp_host_t cur_ff;
    idehp_host_t nxt_ff;
    logic        in_range;
    // [R1] Only the task-file range is passed
    assign in_range = req_addr >= `IDEHP_IO_BASE && req_addr <= `IDEHP_IO_LAST;
    // Next state
    always_comb
    begin
        nxt_ff      = cur_ff;
        nxt_ff.done = 1'b0;
        nxt_ff.rstn = 1'b1;
        nxt_ff.irq  = bus.drive_interrupt_line;
        case (cur_ff.st)
            IDEHP_H_IDLE:
                if (req)
                begin
                    nxt_ff.wr   = req_wr;
                    nxt_ff.addr = req_addr[2:0];
                    nxt_ff.ctl  = req_addr[3];
                    nxt_ff.wd   = req_wdata;
                    nxt_ff.hold = 4'h0;
                    nxt_ff.rd   = 16'h0000;
                    nxt_ff.st   = in_range ? IDEHP_H_STRB : IDEHP_H_END;
                end
            IDEHP_H_STRB:
            begin
                // [R4] Wait while ready is low
                if (!bus.ready_n)
                    nxt_ff.hold = 4'h0;
                else
                    nxt_ff.hold = cur_ff.hold + 4'h1;
                // [R6] Sample read data
                if (!cur_ff.wr && bus.data_d_oe)
                    nxt_ff.rd = bus.data_d;
                if (bus.ready_n && cur_ff.hold >= `IDEHP_HOST_HOLD)
                    nxt_ff.st = IDEHP_H_END;
            end
            IDEHP_H_END:
            begin
                nxt_ff.done = 1'b1;
                nxt_ff.st   = IDEHP_H_IDLE;
            end
            default: nxt_ff.st = IDEHP_H_IDLE;
        endcase
    end
    // State register
    always_ff @(posedge clk)
    begin
        // [R2] Drive reset held low during reset
        if (rst)
        begin
            cur_ff    <= '0;
            cur_ff.st <= IDEHP_H_IDLE;
        end
        else
            cur_ff <= nxt_ff;
    end
    // [R11] Address lines and strobes
    assign bus.addr      = cur_ff.addr;
    assign bus.cs_ctl    = cur_ff.ctl;
    assign bus.iow_n     = !(cur_ff.st == IDEHP_H_STRB && cur_ff.wr);
    assign bus.ior_n     = !(cur_ff.st == IDEHP_H_STRB && !cur_ff.wr);
    assign bus.ale       = 1'b0;
    assign bus.reset_n   = cur_ff.rstn;
    // [R3] Host drives data only on writes
    assign bus.data_h    = cur_ff.wd;
    assign bus.data_h_oe = cur_ff.st == IDEHP_H_STRB && cur_ff.wr;
    assign busy          = cur_ff.st != IDEHP_H_IDLE;
    assign done          = cur_ff.done;
    assign rdata         = cur_ff.rd;
    assign irq           = cur_ff.irq;
endmodule

/* testbench/idehp_chk.sv */
// Assertions on the cable between the host adapter and the drive
`timescale 1ns/100ps
module idehp_chk
(
    input wire logic       clk,                       // System clock
    input wire logic       rst,                       // Synchronous reset
    input wire logic       data_h_oe,                 // Host drives data
    input wire logic       data_d_oe,                 // Drive drives data
    input wire logic       ready_n,                   // Drive wait request
    input wire logic       iow_n,                     // Write strobe
    input wire logic       ior_n,                     // Read strobe
    input wire logic [2:0] addr,                      // Register select
    input wire logic       cs_ctl,                    // Control block select
    input wire logic       drive_interrupt_line,      // Drive interrupt
    input wire logic       word_transfer_indicator_n  // Word cycle flag
);
    // One clock domain, all checks off in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    one_talker_a:
        assert property (!(data_h_oe && data_d_oe)) else $error("both ends drive the data bus");
    drive_oe_read_a:
        assert property (data_d_oe |-> (!ior_n || !$past(ior_n))) else $error("drive data outside a read");
    write_data_a:
        assert property (!iow_n |-> data_h_oe) else $error("write strobe without host data");
    read_answer_a:
        assert property ($fell(ior_n) |=> data_d_oe) else $error("read strobe not answered");
    ready_in_strobe_a:
        assert property (!ready_n |-> (!ior_n || !iow_n)) else $error("wait asserted outside a cycle");
    strobe_hold_a:
        assert property ((!ready_n && !(ior_n && iow_n)) |=> ($stable(ior_n) && $stable(iow_n)))
            else $error("strobe released during wait");
    wait_bound_a:
        assert property (($fell(ior_n) || $fell(iow_n)) |-> ##[1:4] ready_n) else $error("wait too long");
    word_flag_a:
        assert property (!word_transfer_indicator_n |-> (addr == 3'h0 || $past(addr) == 3'h0))
            else $error("word flag away from data register");
    status_clear_a:
        assert property (($fell(ior_n) && addr == 3'h7 && !cs_ctl) |-> ##[1:8] !drive_interrupt_line)
            else $error("status read left interrupt pending");
    reset_quiet_a:
        assert property ($fell(rst) |-> (!drive_interrupt_line && ready_n && !data_d_oe))
            else $error("drive outputs active after reset");
endmodule

/* testbench/ide_drive_host_port_bench.sv */
// Self-checking bench joining the host adapter and the drive over the cable
`timescale 1ns/100ps
module ide_drive_host_port_bench;
    logic        clk;
    logic        rst;
    logic        req;
    logic        req_wr;
    logic [15:0] req_addr;
    logic [15:0] req_wdata;
    logic        done;
    logic [15:0] rdata;
    logic        irq;
    logic        media_fetch;
    logic        media_ack;
    logic [31:0] media_lba;
    logic [15:0] wire_val;
    logic [15:0] got;
    int          fetch_cnt;
    int          strobe_cnt;
    int          mark;
    int          fail_count;
    int          check_count;
    idehp_if     cable ();

    idehp_host idehp_host_i
    (
        .clk (clk), .rst (rst), .req (req), .req_wr (req_wr), .req_addr (req_addr),
        .req_wdata (req_wdata), .busy (), .done (done), .rdata (rdata), .irq (irq), .bus (cable.host)
    );
    idehp_drive #(.CACHE_AW (6)) idehp_drive_i
    (
        .clk (clk), .rst (rst), .master_select_strap (1'b1), .bus (cable.drive), .media_lba (media_lba),
        .media_fetch (media_fetch), .media_ack (media_ack), .media_word (16'hC3A5)
    );
    idehp_chk idehp_chk_i
    (
        .clk (clk), .rst (rst), .data_h_oe (cable.data_h_oe), .data_d_oe (cable.data_d_oe),
        .ready_n (cable.ready_n), .iow_n (cable.iow_n), .ior_n (cable.ior_n), .addr (cable.addr),
        .cs_ctl (cable.cs_ctl), .drive_interrupt_line (cable.drive_interrupt_line),
        .word_transfer_indicator_n (cable.word_transfer_indicator_n)
    );

    // Clock at 25 MHz
    always #20 clk = ~clk;

    // Media answers each fetch one cycle later
    always @(negedge clk)
        media_ack <= media_fetch && !media_ack;

    // Cable monitor: fetches, strobe cycles, last data seen on the wire
    always @(posedge clk)
    begin
        fetch_cnt  <= fetch_cnt + int'(media_ack);
        strobe_cnt <= strobe_cnt + int'(!cable.ior_n || !cable.iow_n);
        if (!cable.iow_n && cable.data_h_oe)
            wire_val <= cable.data_h;
        if (!cable.ior_n && cable.data_d_oe)
            wire_val <= cable.data_d;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One host I/O cycle, waits for done under a bound
    task automatic io(input logic wr, input logic [15:0] a, input logic [15:0] d);
        int n;
        n         = 0;
        req_wr    = wr;
        req_addr  = a;
        req_wdata = d;
        req       = 1'b1;
        @(negedge clk);
        req = 1'b0;
        while (done !== 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        chk("done", 16'h0001, {15'h0000, done});
        got = rdata;
        @(negedge clk);
    endtask

    task automatic wr(input logic [3:0] ofs, input logic [15:0] d);
        io(1'b1, 16'h01F0 + {12'h000, ofs}, d);
    endtask

    task automatic rd(input logic [3:0] ofs);
        io(1'b0, 16'h01F0 + {12'h000, ofs}, 16'h0000);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        chk("irq raised", 16'h0001, {15'h0000, irq});
    endtask

    task automatic t_taskfile();
        for (int i = 2; i < 6; i++)
        begin
            wr(4'(i), 16'h00A0 + 16'(i));
            chk("wire write", 16'h00A0 + 16'(i), wire_val);
        end
        for (int i = 2; i < 6; i++)
        begin
            rd(4'(i));
            chk("reg readback", 16'h00A0 + 16'(i), {8'h00, got[7:0]});
            chk("wire read", 16'h00A0 + 16'(i), wire_val);
        end
        $display("test taskfile finished");
    endtask

    task automatic t_range();
        mark = strobe_cnt;
        io(1'b0, 16'h01FA, 16'h0000);
        chk("outside read", 16'h0000, got);
        io(1'b1, 16'h01EF, 16'h0055);
        chk("outside strobes", 16'h0000, 16'(strobe_cnt - mark));
        $display("test range finished");
    endtask

    task automatic t_irq_gate();
        wr(4'h8, 16'h0000);
        wr(4'h6, 16'h0000);
        wr(4'h7, 16'h0010);
        repeat (20) @(negedge clk);
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wr(4'h8, 16'h0002);
        wait_irq();
        rd(4'h7);
        repeat (3) @(negedge clk);
        chk("irq after status", 16'h0000, {15'h0000, irq});
        $display("test irq_gate finished");
    endtask

    task automatic t_read_cache();
        wr(4'h4, 16'h0000);
        wr(4'h5, 16'h0000);
        wr(4'h2, 16'h0001);
        wr(4'h3, 16'h0002);
        wr(4'h7, 16'h0020);
        wait_irq();
        chk("block address", 16'h0001, media_lba[15:0]);
        repeat (2)
        begin
            rd(4'h0);
            chk("data word", 16'hC3A5, got);
            chk("wire data", 16'hC3A5, wire_val);
        end
        rd(4'h7);
        mark = fetch_cnt;
        wr(4'h7, 16'h0020);
        wait_irq();
        chk("cache hit fetches", 16'h0000, 16'(fetch_cnt - mark));
        rd(4'h7);
        $display("test read_cache finished");
    endtask

    task automatic t_format();
        mark = fetch_cnt;
        wr(4'h7, 16'h0050);
        wait_irq();
        chk("format fetches", 16'h0000, 16'(fetch_cnt - mark));
        rd(4'h7);
        $display("test format finished");
    endtask

    task automatic t_reset_clear();
        wr(4'h7, 16'h0010);
        wait_irq();
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("irq after reset", 16'h0000, {15'h0000, irq});
        rd(4'h7);
        chk("status after reset", 16'h0050, {8'h00, got[7:0]});
        $display("test reset_clear finished");
    endtask

    task automatic t_unselected();
        wr(4'h8, 16'h0002);
        wr(4'h6, 16'h0000);
        wr(4'h7, 16'h0010);
        wait_irq();
        wr(4'h6, 16'h0010);
        repeat (3) @(negedge clk);
        chk("irq other drive", 16'h0000, {15'h0000, irq});
        wr(4'h6, 16'h0000);
        wait_irq();
        rd(4'h7);
        $display("test unselected finished");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        clk         = 1'b0;
        rst         = 1'b1;
        req         = 1'b0;
        req_wr      = 1'b0;
        req_addr    = 16'h0000;
        req_wdata   = 16'h0000;
        fail_count  = 0;
        check_count = 0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        rd(4'h7);
        chk("status at reset", 16'h0050, {8'h00, got[7:0]});
        t_taskfile();
        t_range();
        t_irq_gate();
        t_read_cache();
        t_format();
        t_reset_clear();
        t_unselected();
        complete_run();
    end
endmodule
